//--- verilog/lai_irq_status.sv
// Chosen here: the placing of the registers and register access over AXI4-Lite.
module lai_irq_status
	import lai_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [LAI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [LAI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic converter_overflow_i,
	input wire logic tx_jitter_fifo_err_i,
	input wire logic rx_jitter_fifo_err_i,
	input wire logic tx_output_live_i,
	input wire logic tx_clock_missing_live_i,
	input wire logic tx_signal_loss_live_i,
	input wire logic signal_loss_live_i,
	output logic irq_n_o
);
	logic [7:0] flag_r;
	logic [7:0] flag_nxt;
	logic [7:0] edge_sel_r;
	logic [7:0] src_w;
	logic [7:0] any_edge_w;
	logic [7:0] level_w;
	logic [7:0] set_w;
	logic [7:0] clr_w;
	logic irq_n_r;

	logic aw_got_r;
	logic w_got_r;
	logic [LAI_ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	function automatic logic addr_mapped(input logic [LAI_ADDR_W-1:0] a);
		addr_mapped = (a == LAI_OFF_STATUS) || (a == LAI_OFF_EDGE_SEL) || (a == LAI_OFF_LIVE);
	endfunction : addr_mapped

	// Bit 0 has no source here and always reads zero
	assign src_w = {converter_overflow_i, tx_jitter_fifo_err_i, rx_jitter_fifo_err_i,
		tx_output_live_i, tx_clock_missing_live_i, tx_signal_loss_live_i,
		signal_loss_live_i, 1'b0};
	// FIFO and converter faults count on their rising edge only
	assign any_edge_w = edge_sel_r & LAI_EDGE_SEL_MASK;

	genvar gi;
	generate
		for (gi = 0; gi < LAI_NFLAG; gi++) begin : g_src
			lai_edge_detect u_edge (
				.clk_i(clk_i),
				.reset_i(reset_i),
				.level_i(src_w[gi]),
				.any_edge_i(any_edge_w[gi]),
				.level_o(level_w[gi]),
				.event_o(set_w[gi])
			);
		end
	endgenerate

	// Write channel: address and data may arrive in either order
	logic wr_do_w;
	logic ar_fire_w;
	logic wr_stat_w;
	logic wr_esel_w;
	logic [31:0] rd_mux_w;

	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign wr_do_w = aw_got_r && w_got_r && !bvalid_r;
	assign wr_stat_w = wr_do_w && (awaddr_r == LAI_OFF_STATUS) && wstrb_r[0];
	assign wr_esel_w = wr_do_w && (awaddr_r == LAI_OFF_EDGE_SEL) && wstrb_r[0];
	assign clr_w = wr_stat_w ? wdata_r[7:0] : 8'h00;
	// Set wins over a clear landing in the same cycle
	assign flag_nxt = ((flag_r & ~clr_w) | set_w) & LAI_FLAG_MASK;

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= LAI_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_do_w) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= addr_mapped(awaddr_r) ? LAI_RESP_OKAY : LAI_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Read channel: one outstanding read, data registered
	assign s_axi_arready = !rvalid_r;
	assign ar_fire_w = s_axi_arvalid && s_axi_arready;
	assign rd_mux_w = (s_axi_araddr == LAI_OFF_STATUS) ? {24'h000000, flag_r} :
		(s_axi_araddr == LAI_OFF_EDGE_SEL) ? {24'h000000, edge_sel_r} :
		(s_axi_araddr == LAI_OFF_LIVE) ? {24'h000000, level_w} : 32'h0000_0000;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= LAI_RESP_OKAY;
		end else if (ar_fire_w) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux_w;
			rresp_r <= addr_mapped(s_axi_araddr) ? LAI_RESP_OKAY : LAI_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			flag_r <= LAI_FLAG_RST;
			edge_sel_r <= LAI_EDGE_SEL_RST;
			irq_n_r <= 1'b1;
		end else begin
			flag_r <= flag_nxt;
			if (wr_esel_w) begin
				edge_sel_r <= wdata_r[7:0] & LAI_EDGE_SEL_MASK;
			end
			irq_n_r <= ~|flag_nxt;
		end
	end

	assign irq_n_o = irq_n_r;

	property p_reset_clear;
		@(posedge clk_i) reset_i |=> (flag_r == 8'h00) && irq_n_o;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("flags not zero after reset");

	property p_w1c;
		@(posedge clk_i) disable iff (reset_i)
		(wr_stat_w && (set_w == 8'h00)) |=> ((flag_r & $past(wdata_r[7:0])) == 8'h00);
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

	property p_rise_only;
		@(posedge clk_i) disable iff (reset_i)
		(set_w[LAI_BIT_SIG_LOSS] && !edge_sel_r[LAI_BIT_SIG_LOSS]) |=> level_w[LAI_BIT_SIG_LOSS];
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("falling edge set signal loss flag");

	property p_any_edge_sl;
		@(posedge clk_i) disable iff (reset_i)
		($changed(level_w[LAI_BIT_SIG_LOSS]) && $past(edge_sel_r[LAI_BIT_SIG_LOSS]))
			|-> flag_r[LAI_BIT_SIG_LOSS];
	endproperty
	a_any_edge_sl: assert property (p_any_edge_sl) else $error("signal loss change missed");

	property p_tx_loss;
		@(posedge clk_i) disable iff (reset_i)
		($rose(level_w[LAI_BIT_TX_LOSS]) ||
			($fell(level_w[LAI_BIT_TX_LOSS]) && $past(edge_sel_r[LAI_BIT_TX_LOSS])))
			|-> flag_r[LAI_BIT_TX_LOSS];
	endproperty
	a_tx_loss: assert property (p_tx_loss) else $error("tx loss change missed");

	property p_tx_clk;
		@(posedge clk_i) disable iff (reset_i)
		($fell(level_w[LAI_BIT_TX_CLK]) && !$past(edge_sel_r[LAI_BIT_TX_CLK])
			&& !$past(flag_r[LAI_BIT_TX_CLK])) |-> !flag_r[LAI_BIT_TX_CLK];
	endproperty
	a_tx_clk: assert property (p_tx_clk) else $error("tx clock flag set on fall");

	property p_tx_out;
		@(posedge clk_i) disable iff (reset_i)
		($changed(level_w[LAI_BIT_TX_OUT]) && ($past(edge_sel_r[LAI_BIT_TX_OUT])
			|| level_w[LAI_BIT_TX_OUT])) |-> flag_r[LAI_BIT_TX_OUT];
	endproperty
	a_tx_out: assert property (p_tx_out) else $error("tx output change missed");

	property p_set_wins;
		@(posedge clk_i) disable iff (reset_i)
		(set_w[LAI_BIT_TX_FIFO] || set_w[LAI_BIT_RX_FIFO]) |=>
			((flag_r & $past(set_w)) == ($past(set_w) & LAI_FLAG_MASK)) && !irq_n_o;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("set event lost");

	property p_conv_hold;
		@(posedge clk_i) disable iff (reset_i)
		(flag_r[LAI_BIT_CONV] && !(wr_stat_w && wdata_r[LAI_BIT_CONV]))
			|=> flag_r[LAI_BIT_CONV] && !irq_n_o;
	endproperty
	a_conv_hold: assert property (p_conv_hold) else $error("converter flag dropped");

	property p_irq_pin;
		@(posedge clk_i) disable iff (reset_i)
		##1 (irq_n_o == (flag_r == 8'h00));
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin disagrees with flags");

	// Guarded by the past reset so the flags wiped by a reset do not count as lost
	property p_keep_flag;
		@(posedge clk_i) disable iff (reset_i)
		!$past(reset_i) |-> (($past(flag_r) & ~flag_r & ~$past(clr_w)) == 8'h00);
	endproperty
	a_keep_flag: assert property (p_keep_flag) else $error("flag lost");

	property p_sl_rise;
		@(posedge clk_i) disable iff (reset_i)
		$rose(level_w[LAI_BIT_SIG_LOSS]) |-> flag_r[LAI_BIT_SIG_LOSS];
	endproperty
	a_sl_rise: assert property (p_sl_rise) else $error("signal loss rise missed");

	property p_sl_fall;
		@(posedge clk_i) disable iff (reset_i)
		($fell(level_w[LAI_BIT_SIG_LOSS]) && !$past(edge_sel_r[LAI_BIT_SIG_LOSS])
			&& !$past(flag_r[LAI_BIT_SIG_LOSS])) |-> !flag_r[LAI_BIT_SIG_LOSS];
	endproperty
	a_sl_fall: assert property (p_sl_fall) else $error("signal loss set on fall");

	property p_tl_fall;
		@(posedge clk_i) disable iff (reset_i)
		($fell(level_w[LAI_BIT_TX_LOSS]) && !$past(edge_sel_r[LAI_BIT_TX_LOSS])
			&& !$past(flag_r[LAI_BIT_TX_LOSS])) |-> !flag_r[LAI_BIT_TX_LOSS];
	endproperty
	a_tl_fall: assert property (p_tl_fall) else $error("tx loss set on fall");

	property p_tc_set;
		@(posedge clk_i) disable iff (reset_i)
		($rose(level_w[LAI_BIT_TX_CLK]) ||
			($fell(level_w[LAI_BIT_TX_CLK]) && $past(edge_sel_r[LAI_BIT_TX_CLK])))
			|-> flag_r[LAI_BIT_TX_CLK];
	endproperty
	a_tc_set: assert property (p_tc_set) else $error("tx clock change missed");

	property p_fault_rise;
		@(posedge clk_i) disable iff (reset_i)
		!$past(reset_i) |->
			((~$past(level_w) & level_w & ~flag_r & LAI_FLAG_MASK & ~LAI_EDGE_SEL_MASK) == 8'h00);
	endproperty
	a_fault_rise: assert property (p_fault_rise) else $error("fault rise missed");

	property p_fault_fall;
		@(posedge clk_i) disable iff (reset_i)
		!$past(reset_i) |-> (($past(level_w) & ~level_w & ~$past(flag_r) & flag_r
			& LAI_FLAG_MASK & ~LAI_EDGE_SEL_MASK) == 8'h00);
	endproperty
	a_fault_fall: assert property (p_fault_fall) else $error("fault set on fall");

	property p_b_hold;
		@(posedge clk_i) disable iff (reset_i)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");

	property p_r_hold;
		@(posedge clk_i) disable iff (reset_i)
		(s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata)
			&& $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");

	property p_bad_addr;
		@(posedge clk_i) disable iff (reset_i)
		(wr_do_w && !addr_mapped(awaddr_r)) |=> (s_axi_bresp == LAI_RESP_SLVERR);
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("unmapped write not refused");
endmodule : lai_irq_status

//--- verilog/lai_pkg.sv
package lai_pkg;
	localparam int LAI_ADDR_W = 4;
	localparam logic [LAI_ADDR_W-1:0] LAI_OFF_STATUS = 4'h0;
	localparam logic [LAI_ADDR_W-1:0] LAI_OFF_EDGE_SEL = 4'h4;
	localparam logic [LAI_ADDR_W-1:0] LAI_OFF_LIVE = 4'h8;
	localparam int LAI_NFLAG = 8;
	localparam int LAI_BIT_LINE_LOSS = 0;
	localparam int LAI_BIT_SIG_LOSS = 1;
	localparam int LAI_BIT_TX_LOSS = 2;
	localparam int LAI_BIT_TX_CLK = 3;
	localparam int LAI_BIT_TX_OUT = 4;
	localparam int LAI_BIT_RX_FIFO = 5;
	localparam int LAI_BIT_TX_FIFO = 6;
	localparam int LAI_BIT_CONV = 7;
	localparam logic [7:0] LAI_FLAG_RST = 8'h00;
	localparam logic [7:0] LAI_FLAG_MASK = 8'hFE;
	localparam logic [7:0] LAI_EDGE_SEL_RST = 8'h00;
	localparam logic [7:0] LAI_EDGE_SEL_MASK = 8'h1E;
	localparam logic [1:0] LAI_RESP_OKAY = 2'h0;
	localparam logic [1:0] LAI_RESP_SLVERR = 2'h2;
endpackage : lai_pkg

//--- verilog/lai_edge_detect.sv
module lai_edge_detect
	import lai_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic level_i,
	input wire logic any_edge_i,
	output logic level_o,
	output logic event_o
);
	logic sync1_r;
	logic sync2_r;
	logic sync3_r;
	logic level_r;
	logic agree_w;
	logic level_nxt;

	// A change counts only once the second and third stages agree
	assign agree_w = (sync2_r == sync3_r);
	assign level_nxt = agree_w ? sync3_r : level_r;
	assign level_o = level_r;
	assign event_o = (level_nxt != level_r) && (any_edge_i || level_nxt);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
			level_r <= 1'b0;
		end else begin
			sync1_r <= level_i;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			level_r <= level_nxt;
		end
	end
endmodule : lai_edge_detect

//--- tb/lai_host.sv
module lai_host
	import lai_pkg::*;
(
	input wire logic clk_i,
	output logic [LAI_ADDR_W-1:0] awaddr_o = '0,
	output logic awvalid_o = 1'b0,
	input wire logic awready_i,
	output logic [31:0] wdata_o = '0,
	output logic wvalid_o = 1'b0,
	input wire logic wready_i,
	input wire logic bvalid_i,
	output logic bready_o = 1'b0,
	output logic [LAI_ADDR_W-1:0] araddr_o = '0,
	output logic arvalid_o = 1'b0,
	input wire logic arready_i,
	input wire logic rvalid_i,
	output logic rready_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// Readies are sampled mid-cycle, so the decision never races the slave's edge updates
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic ta;
		logic tw;
		logic tb;
		awaddr_o <= a;
		wdata_o <= {24'h0, d};
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		do begin
			@(negedge clk_i);
			ta = awvalid_o && awready_i;
			tw = wvalid_o && wready_i;
			tb = bvalid_i && bready_o;
			@(posedge clk_i);
			if (ta) awvalid_o <= 1'b0;
			if (tw) wvalid_o <= 1'b0;
		end while (!tb);
		bready_o <= 1'b0;
		// One edge passes so a following call never re-raises a ready in the same step
		@(posedge clk_i);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		logic ta;
		logic tr;
		araddr_o <= a;
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		do begin
			@(negedge clk_i);
			ta = arvalid_o && arready_i;
			tr = rvalid_i && rready_o;
			@(posedge clk_i);
			if (ta) arvalid_o <= 1'b0;
		end while (!tr);
		rready_o <= 1'b0;
		@(posedge clk_i);
	endtask : rd
endmodule : lai_host

//--- tb/tb_top.sv
module tb_top
	import lai_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:1] src = '0;
	logic [LAI_ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq_n;
	logic [33:0] exp_q[$];
	int err_total = 0;
	int checked = 0;
	int seed = 32'h7389;
	logic [31:0] v;
	logic [3:0] wstrb = 4'hF;
	lai_host u_host (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
		.awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready),
		.bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
		.arready_i(arready), .rvalid_i(rvalid), .rready_o(rready));
	lai_irq_status u_dut (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .converter_overflow_i(src[7]), .tx_jitter_fifo_err_i(src[6]),
		.rx_jitter_fifo_err_i(src[5]), .tx_output_live_i(src[4]),
		.tx_clock_missing_live_i(src[3]), .tx_signal_loss_live_i(src[2]),
		.signal_loss_live_i(src[1]), .irq_n_o(irq_n));
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	task automatic chk(input logic [33:0] got, input logic [33:0] e);
		checked++;
		if (got !== e) begin
			$display("unexpected at %0t: got %h want %h", $time, got, e);
			err_total++;
		end
	endtask : chk
	// The pin is looked at mid-cycle, where it has settled
	task automatic chk_irq(input logic e);
		@(negedge clk_i);
		chk(34'(irq_n), 34'(e));
		@(posedge clk_i);
	endtask : chk_irq
	always @(posedge clk_i) begin
		if (bvalid && bready) chk({bresp, 32'h0}, exp_q.pop_front());
		if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
	end
	task automatic rdx(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
		exp_q.push_back({r, 24'h0, d});
		u_host.rd(a);
	endtask : rdx
	task automatic wrx(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
		exp_q.push_back({r, 32'h0});
		u_host.wr(a, d);
	endtask : wrx
	// Inputs pass a three-stage filter, so allow margin before looking
	task automatic settle();
		repeat (8) @(posedge clk_i);
	endtask : settle
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		#2000000;
		err_total++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		rdx(LAI_OFF_STATUS, 8'h00);
		rdx(LAI_OFF_EDGE_SEL, 8'h00);
		chk_irq(1'b1);
		$display("test reset done");
		for (int i = 1; i < 8; i++) begin
			src[i] <= 1'b1;
			settle();
			rdx(LAI_OFF_LIVE, 8'h01 << i);
			rdx(LAI_OFF_STATUS, 8'h01 << i);
			chk_irq(1'b0);
			wrx(LAI_OFF_STATUS, 8'h01 << i);
			src[i] <= 1'b0;
			settle();
			rdx(LAI_OFF_STATUS, 8'h00);
			chk_irq(1'b1);
		end
		$display("test rising done");
		wrx(LAI_OFF_EDGE_SEL, 8'h1E);
		src[4:1] <= 4'hF;
		settle();
		wrx(LAI_OFF_STATUS, 8'h1E);
		rdx(LAI_OFF_STATUS, 8'h00);
		src[4:1] <= 4'h0;
		settle();
		rdx(LAI_OFF_STATUS, 8'h1E);
		wrx(LAI_OFF_STATUS, 8'h02);
		rdx(LAI_OFF_STATUS, 8'h1C);
		chk_irq(1'b0);
		// Without the low byte strobe the clear must not land
		wstrb <= 4'h0;
		wrx(LAI_OFF_STATUS, 8'h1C);
		wstrb <= 4'hF;
		rdx(LAI_OFF_STATUS, 8'h1C);
		wrx(LAI_OFF_STATUS, 8'h1C);
		chk_irq(1'b1);
		$display("test any edge done");
		// The write is timed so its clear lands at the edge the filtered rise sets the flag
		src[6] <= 1'b1;
		repeat (2) @(posedge clk_i);
		wrx(LAI_OFF_STATUS, 8'h40);
		rdx(LAI_OFF_STATUS, 8'h40);
		src[6] <= 1'b0;
		settle();
		wrx(LAI_OFF_STATUS, 8'h40);
		rdx(LAI_OFF_STATUS, 8'h00);
		$display("test set wins done");
		repeat (4) begin
			v = $random(seed);
			wrx(LAI_OFF_EDGE_SEL, v[7:0]);
			rdx(LAI_OFF_EDGE_SEL, v[7:0] & LAI_EDGE_SEL_MASK);
		end
		wrx(4'hC, 8'hFF, LAI_RESP_SLVERR);
		rdx(4'hC, 8'h00, LAI_RESP_SLVERR);
		$display("test registers done");
		src[7] <= 1'b1;
		settle();
		src[7] <= 1'b0;
		settle();
		chk_irq(1'b0);
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		rdx(LAI_OFF_STATUS, 8'h00);
		rdx(LAI_OFF_EDGE_SEL, 8'h00);
		chk_irq(1'b1);
		$display("test mid-run reset done");
		repeat (2) @(posedge clk_i);
		stop_test();
	end
endmodule : tb_top
